/* File: shared/ifd_pkg.sv */
// shared constants, enumerations and the decoded-instruction carrier
// assumes one core clock per oscillator period and 16-bit program words
`default_nettype none

package ifd_pkg;

    // ------------------------------------------------------------------
    // instruction set size and word layout
    // ------------------------------------------------------------------
    localparam int IFD_STD_COUNT = 75;       // core instructions
    localparam int IFD_EXT_COUNT = 8;        // extended (software stack) instructions
    localparam int IFD_WORD_W = 16;
    localparam logic [3:0] IFD_SECOND_TAG = 4'hF;   // top nibble of every second word

    // ------------------------------------------------------------------
    // cycle timing
    // ------------------------------------------------------------------
    localparam int IFD_OSC_PER_CYCLE = 4;
    localparam logic [1:0] IFD_LAST_PHASE = 2'(IFD_OSC_PER_CYCLE - 1);
    localparam logic [1:0] IFD_FIRST_PHASE = 2'h0;
    localparam logic [1:0] IFD_PHASE_STEP = 2'h1;
    localparam logic [1:0] IFD_CYC_ONE = 2'h1;
    localparam logic [1:0] IFD_CYC_TWO = 2'h2;

    // ------------------------------------------------------------------
    // opcode groups, top nibble and second nibble
    // ------------------------------------------------------------------
    localparam logic [3:0] IFD_OP_MISC = 4'h0;
    localparam logic [3:0] IFD_OP_BIT_LO = 4'h7;
    localparam logic [3:0] IFD_OP_BIT_HI = 4'hB;
    localparam logic [3:0] IFD_OP_BIT_SKIP = 4'hA;  // this and next nibble test a bit
    localparam logic [3:0] IFD_OP_MOVE_FF = 4'hC;
    localparam logic [3:0] IFD_OP_REL_BR = 4'hD;
    localparam logic [3:0] IFD_OP_GRP_E = 4'hE;
    localparam logic [3:0] IFD_OP_BYTE_6 = 4'h6;
    localparam logic [3:0] IFD_SUB_BANK = 4'h1;
    localparam logic [3:0] IFD_SUB_LIT_LO = 4'h8;
    localparam logic [3:0] IFD_SUB_ADD_FSR = 4'h8;
    localparam logic [3:0] IFD_SUB_SUB_FSR = 4'h9;
    localparam logic [3:0] IFD_SUB_PUSH_LIT = 4'hA;
    localparam logic [3:0] IFD_SUB_MOVE_STK = 4'hB;
    localparam logic [3:0] IFD_SUB_CALL_LO = 4'hC;
    localparam logic [3:0] IFD_SUB_CALL_HI = 4'hD;
    localparam logic [3:0] IFD_SUB_LOAD_FSR = 4'hE;
    localparam logic [3:0] IFD_SUB_GOTO = 4'hF;
    localparam logic [15:0] IFD_WORD_CALL_W = 16'h0014;
    localparam logic [4:0] IFD_TBL_PREFIX = 5'h01;     // bits 7:3 of a table access
    localparam logic [6:0] IFD_RET_PREFIX = 7'h09;     // bits 7:1 of return
    localparam logic [6:0] IFD_RETI_PREFIX = 7'h08;    // bits 7:1 of return from interrupt
    localparam logic [5:0] IFD_SKIP_DEC_Z = 6'h0B;     // bits 15:10, decrement skip if zero
    localparam logic [5:0] IFD_SKIP_INC_Z = 6'h0F;
    localparam logic [5:0] IFD_SKIP_INC_NZ = 6'h12;
    localparam logic [5:0] IFD_SKIP_DEC_NZ = 6'h13;
    localparam logic [2:0] IFD_SKIP_CMP = 3'h0;        // low two bits match bits 11:10 of 0x6 group, compares

    // ------------------------------------------------------------------
    // enumerations and carrier
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        IFD_CAT_BYTE,
        IFD_CAT_BIT,
        IFD_CAT_LIT,
        IFD_CAT_CTRL
    } ifd_cat_t;

    // encoding follows the two-bit mode field of the table instructions
    typedef enum logic [1:0] {
        IFD_TBL_KEEP,
        IFD_TBL_POST_INC,
        IFD_TBL_POST_DEC,
        IFD_TBL_PRE_INC
    } ifd_tbl_t;

    typedef struct packed {
        ifd_cat_t cat;
        logic ext_set;
        logic double_word;
        logic orphan_nop;
        logic conditional;
        logic pc_change;
        logic [1:0] cycles;
        logic [11:0] file_addr;
        logic [11:0] dest_addr;
        logic has_dest;
        logic dest_to_freg;
        logic dest_to_accum;
        logic uses_ram;
        logic access_ram;
        logic bank_select;
        logic [2:0] bit_num;
        logic [11:0] literal;
        logic [1:0] fsr_sel;
        logic [19:0] prog_addr;
        logic fast_mode;
        logic shadow_update;
        logic tbl_access;
        ifd_tbl_t tbl_mode;
        logic [15:0] word_hi;
        logic [15:0] word_lo;
    } ifd_dec_t;

endpackage : ifd_pkg

`default_nettype wire

/* File: logic/ifd_word_store.sv */
// one-word store holding the first half of a double-word instruction
// assumes write and read are at least one clock apart; read data registered
`default_nettype none

module ifd_word_store (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic wr_en,
    input wire logic [15:0] wr_data,
    output logic [15:0] rd_data
);
    import ifd_pkg::*;

    logic [15:0] mem_q;
    logic [15:0] mem_d;
    logic [15:0] rd_q;

    // ------------------------------------------------------------------
    // storage and registered read
    // ------------------------------------------------------------------
    always_comb begin
        mem_d = wr_en ? wr_data : mem_q;
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            mem_q <= 16'h0000;
            rd_q <= 16'h0000;
        end else begin
            mem_q <= mem_d;
            rd_q <= mem_q;   // one clock of read latency
        end
    end

    assign rd_data = rd_q;

endmodule : ifd_word_store

`default_nettype wire

/* File: logic/ifd_decoder.sv */
// instruction format decoder and instruction cycle sequencer
// assumes program memory presents a word with pm_valid at the last phase
// of each instruction cycle, and execute reports cond_taken by the next one
`default_nettype none

// Function
// - recognise the 75 core instructions and 8 extended ones when enabled
// - a single-word instruction is one 16-bit word: opcode plus operand fields
// - exactly four core instructions span two consecutive words, 32 bits
// - second words start with four ones and run alone as a no-operation
// - one cycle normally; two when a test is true or PC changes
// - every double-word instruction takes two instruction cycles
// - one instruction cycle is four oscillator periods
// - classify as byte, bit, literal or control
// - byte ops carry file address, destination bit and access bit
// - destination zero writes accumulator, one writes the file register
// - bit ops carry file address, bit number and access bit
// - literal ops carry a constant, a pointer select, or nothing
// - control ops carry program address, fast bit, table mode, or nothing
// - access bit zero uses access RAM, one uses the bank select register
// - fast bit set saves or restores shadow registers, clear leaves them
// - table mode: pointer kept, post-increment, post-decrement or pre-increment
module ifd_decoder (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] pm_word,
    input wire logic pm_valid,
    output logic pm_ready,
    input wire logic ext_set_en,
    input wire logic cond_taken,
    output logic [1:0] cycle_phase,
    output logic cycle_start,
    output logic issue,
    output logic flush_cycle,
    output ifd_pkg::ifd_dec_t dec
);
    import ifd_pkg::*;

    typedef enum logic [1:0] {
        ST_EXEC,
        ST_EXT_WORD,
        ST_FLUSH
    } ifd_state_t;

    // ------------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------------

    // plain no-operation, also used for skipped and orphan words
    function automatic ifd_dec_t ifd_nop(input logic [15:0] w, input logic orphan);
        ifd_dec_t d;
        d = '0;
        d.cat = IFD_CAT_CTRL;
        d.cycles = IFD_CYC_ONE;
        d.word_hi = w;
        d.orphan_nop = orphan;
        return d;
    endfunction : ifd_nop

    // first-word decode; used at fetch and again on the stored word
    function automatic ifd_dec_t ifd_decode_word(input logic [15:0] w, input logic ext_en);
        ifd_dec_t d;
        logic [3:0] hi;
        logic [3:0] sub;
        d = ifd_nop(w, 1'b0);
        hi = w[15:12];
        sub = w[11:8];
        d.file_addr = {4'h0, w[7:0]};
        d.bit_num = w[11:9];
        d.literal = {4'h0, w[7:0]};
        if (hi == IFD_SECOND_TAG) begin
            d.orphan_nop = 1'b1;
        end else if (hi >= IFD_OP_BIT_LO && hi <= IFD_OP_BIT_HI) begin
            d.cat = IFD_CAT_BIT;
            d.uses_ram = 1'b1;
            d.conditional = (hi >= IFD_OP_BIT_SKIP);
        end else if (hi == IFD_OP_MOVE_FF) begin
            d.cat = IFD_CAT_BYTE;
            d.double_word = 1'b1;
            d.file_addr = w[11:0];
        end else if (hi == IFD_OP_REL_BR) begin
            d.cat = IFD_CAT_CTRL;
            d.pc_change = 1'b1;
            d.prog_addr = {{9{w[10]}}, w[10:0]};
        end else if (hi == IFD_OP_GRP_E) begin
            if (sub < IFD_SUB_ADD_FSR) begin
                d.conditional = 1'b1;                               // branch on status
                d.prog_addr = {{12{w[7]}}, w[7:0]};
            end else if (sub == IFD_SUB_ADD_FSR || sub == IFD_SUB_SUB_FSR) begin
                d.cat = IFD_CAT_LIT;
                d.ext_set = 1'b1;
                d.fsr_sel = w[7:6];
                d.literal = {6'h00, w[5:0]};
            end else if (sub == IFD_SUB_PUSH_LIT) begin
                d.cat = IFD_CAT_LIT;
                d.ext_set = 1'b1;
            end else if (sub == IFD_SUB_MOVE_STK) begin
                d.cat = IFD_CAT_BYTE;
                d.ext_set = 1'b1;
                d.double_word = 1'b1;
                d.file_addr = {5'h00, w[6:0]};
            end else if (sub == IFD_SUB_CALL_LO || sub == IFD_SUB_CALL_HI) begin
                d.double_word = 1'b1;
                d.pc_change = 1'b1;
                d.fast_mode = w[8];
                d.shadow_update = w[8];
            end else if (sub == IFD_SUB_LOAD_FSR) begin
                d.cat = IFD_CAT_LIT;
                d.double_word = 1'b1;
                d.fsr_sel = w[5:4];
            end else begin
                d.double_word = 1'b1;                               // absolute jump
                d.pc_change = 1'b1;
            end
        end else if (hi == IFD_OP_MISC && sub == 4'h0) begin
            if (w == IFD_WORD_CALL_W) begin
                d.ext_set = 1'b1;
                d.pc_change = 1'b1;
            end else if (w[7:3] == IFD_TBL_PREFIX) begin
                d.tbl_access = 1'b1;
                d.tbl_mode = ifd_tbl_t'(w[1:0]);
            end else if (w[7:1] == IFD_RET_PREFIX || w[7:1] == IFD_RETI_PREFIX) begin
                d.pc_change = 1'b1;
                d.fast_mode = w[0];
                d.shadow_update = w[0];
            end
        end else if (hi == IFD_OP_MISC && (sub == IFD_SUB_BANK || sub >= IFD_SUB_LIT_LO)) begin
            d.cat = IFD_CAT_LIT;
        end else begin
            d.cat = IFD_CAT_BYTE;
            d.uses_ram = 1'b1;
            d.has_dest = (hi != IFD_OP_BYTE_6) && !(hi == IFD_OP_MISC && !sub[2]);
            d.conditional = (w[15:10] == IFD_SKIP_DEC_Z) || (w[15:10] == IFD_SKIP_INC_Z)
                || (w[15:10] == IFD_SKIP_INC_NZ) || (w[15:10] == IFD_SKIP_DEC_NZ)
                || (hi == IFD_OP_BYTE_6 && w[11:10] == IFD_SKIP_CMP[1:0]);
            d.dest_to_freg = d.has_dest ? w[9] : (hi == IFD_OP_BYTE_6 && w[11]);
            d.dest_to_accum = d.has_dest && !w[9];
        end
        // ram operand bank choice: access bit low ignores bank select
        if (d.uses_ram) begin
            d.access_ram = !w[8];
            d.bank_select = w[8];
        end
        // extended encodings are plain no-operations while the set is off
        if (d.ext_set && !ext_en) begin
            d = ifd_nop(w, 1'b0);
        end
        d.cycles = (d.double_word || d.pc_change) ? IFD_CYC_TWO : IFD_CYC_ONE;
        return d;
    endfunction : ifd_decode_word

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    logic [1:0] phase_q;
    logic [1:0] phase_d;
    ifd_state_t state_q;
    ifd_state_t state_d;
    ifd_dec_t dec_q;
    ifd_dec_t dec_d;
    logic issue_q;
    logic issue_d;
    logic cond_pend_q;
    logic cond_pend_d;
    logic flush_q;
    logic flush_d;
    logic store_we;
    logic [15:0] store_rd;
    logic boundary;
    ifd_dec_t first_dec;
    ifd_dec_t held_dec;

    ifd_word_store u_store (
        .core_clk(core_clk),
        .sys_rst(sys_rst),
        .wr_en(store_we),
        .wr_data(pm_word),
        .rd_data(store_rd)
    );

    // ------------------------------------------------------------------
    // phase counter and sequencer
    // ------------------------------------------------------------------

    // one word is taken per instruction cycle, at its last phase
    assign boundary = (phase_q == IFD_LAST_PHASE);
    assign first_dec = ifd_decode_word(pm_word, ext_set_en);
    assign held_dec = ifd_decode_word(store_rd, ext_set_en);

    // a skipped double-word lets its second word through; the tag makes it a nop
    always_comb begin
        phase_d = phase_q + IFD_PHASE_STEP;
        state_d = state_q;
        dec_d = dec_q;
        issue_d = 1'b0;
        flush_d = 1'b0;
        cond_pend_d = cond_pend_q;
        store_we = 1'b0;
        if (boundary) begin
            case (state_q)
                ST_EXEC: begin
                    if (pm_valid && cond_pend_q && cond_taken) begin
                        dec_d = ifd_nop(pm_word, 1'b0);
                        issue_d = 1'b1;
                        flush_d = 1'b1;
                        cond_pend_d = 1'b0;
                    end else if (pm_valid && first_dec.double_word) begin
                        store_we = 1'b1;
                        state_d = ST_EXT_WORD;
                        cond_pend_d = 1'b0;
                    end else if (pm_valid) begin
                        dec_d = first_dec;
                        issue_d = 1'b1;
                        cond_pend_d = first_dec.conditional;
                        if (first_dec.pc_change) begin
                            state_d = ST_FLUSH;
                        end
                    end
                end
                ST_EXT_WORD: begin
                    // the second fetch cycle is the instruction's second cycle
                    if (pm_valid) begin
                        dec_d = held_dec;
                        dec_d.word_lo = pm_word;
                        dec_d.dest_addr = pm_word[11:0];
                        if (held_dec.cat == IFD_CAT_LIT) begin
                            dec_d.literal = {store_rd[3:0], pm_word[7:0]};
                        end
                        if (held_dec.cat == IFD_CAT_CTRL) begin
                            dec_d.prog_addr = {pm_word[11:0], store_rd[7:0]};
                        end
                        issue_d = 1'b1;
                        state_d = ST_EXEC;
                    end
                end
                ST_FLUSH: begin
                    // the prefetched word is stale after a jump and is dropped
                    dec_d = ifd_nop(pm_word, 1'b0);
                    issue_d = 1'b1;
                    flush_d = 1'b1;
                    state_d = ST_EXEC;
                end
                default: begin
                    state_d = ST_EXEC;
                end
            endcase
        end
    end

    always_ff @(posedge core_clk) begin
        if (sys_rst) begin
            phase_q <= IFD_FIRST_PHASE;
            state_q <= ST_EXEC;
            dec_q <= '0;
            issue_q <= 1'b0;
            flush_q <= 1'b0;
            cond_pend_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            state_q <= state_d;
            dec_q <= dec_d;
            issue_q <= issue_d;
            flush_q <= flush_d;
            cond_pend_q <= cond_pend_d;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------

    // ready only at the word-taking phase; a flush still accepts and drops
    assign pm_ready = boundary;
    assign cycle_phase = phase_q;
    assign cycle_start = (phase_q == IFD_FIRST_PHASE);
    assign issue = issue_q;
    assign flush_cycle = flush_q;
    assign dec = dec_q;

endmodule : ifd_decoder

`default_nettype wire

/* File: testbench/ifd_decoder_properties.sv */
// timing and decode checks on the decoder's ports
// assumes one core clock and a synchronous active-high reset
`default_nettype none

module ifd_decoder_properties (
    input wire logic core_clk,
    input wire logic sys_rst,
    input wire logic [15:0] pm_word,
    input wire logic pm_valid,
    input wire logic pm_ready,
    input wire logic ext_set_en,
    input wire logic cond_taken,
    input wire logic [1:0] cycle_phase,
    input wire logic cycle_start,
    input wire logic issue,
    input wire logic flush_cycle,
    input wire ifd_pkg::ifd_dec_t dec
);
    import ifd_pkg::*;

    // --------------------------------
    // sequences and properties
    // --------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (sys_rst);

    // at most one issue per instruction cycle
    sequence s_quiet3;
        !issue [*3];
    endsequence
    sequence s_double_done;
        issue && !flush_cycle && dec.double_word;
    endsequence

    property p_phase_step;
        !$past(sys_rst) |-> cycle_phase == 2'($past(cycle_phase) + IFD_PHASE_STEP);
    endproperty
    property p_ready_phase;
        pm_ready == (cycle_phase == IFD_LAST_PHASE);
    endproperty
    property p_start_phase;
        cycle_start == (cycle_phase == IFD_FIRST_PHASE);
    endproperty
    property p_issue_after;
        issue |-> $past(pm_ready) && cycle_phase == IFD_FIRST_PHASE;
    endproperty
    property p_issue_pulse;
        issue |=> s_quiet3;
    endproperty
    property p_flush_issue;
        flush_cycle |-> issue;
    endproperty
    property p_double_cycles;
        s_double_done |-> dec.cycles == IFD_CYC_TWO;
    endproperty
    // a pair's first word is never issued alone
    property p_first_quiet;
        s_double_done |-> $past(issue, 4) == 1'b0;
    endproperty
    property p_orphan;
        issue && dec.orphan_nop |-> !dec.double_word && dec.cycles == IFD_CYC_ONE;
    endproperty
    property p_dest;
        issue && dec.has_dest |-> dec.dest_to_freg != dec.dest_to_accum;
    endproperty
    property p_bank;
        issue && dec.uses_ram |-> dec.bank_select != dec.access_ram;
    endproperty
    property p_hold;
        !$past(sys_rst) && !issue |-> $stable(dec);
    endproperty
    property p_ext_off;
        issue && !ext_set_en |-> !dec.ext_set;
    endproperty

    // --------------------------------
    // assertions
    // --------------------------------
    a_phase_step: assert property (p_phase_step) else $error("phase did not step");
    a_ready_phase: assert property (p_ready_phase) else $error("ready off phase");
    a_start_phase: assert property (p_start_phase) else $error("start off phase");
    a_issue_after: assert property (p_issue_after) else $error("issue off boundary");
    a_issue_pulse: assert property (p_issue_pulse) else $error("issue too close");
    a_flush_issue: assert property (p_flush_issue) else $error("flush without issue");
    a_double_cycles: assert property (p_double_cycles) else $error("pair cycles");
    a_first_quiet: assert property (p_first_quiet) else $error("first word issued");
    a_orphan: assert property (p_orphan) else $error("orphan decode");
    a_dest: assert property (p_dest) else $error("destination flags");
    a_bank: assert property (p_bank) else $error("bank flags");
    a_hold: assert property (p_hold) else $error("decode changed idle");
    a_ext_off: assert property (p_ext_off) else $error("extended while off");
    c_flush: cover property (issue && flush_cycle);
    c_pair: cover property (s_double_done);
endmodule : ifd_decoder_properties

bind ifd_decoder ifd_decoder_properties u_props (.core_clk(core_clk), .sys_rst(sys_rst),
    .pm_word(pm_word), .pm_valid(pm_valid), .pm_ready(pm_ready), .ext_set_en(ext_set_en),
    .cond_taken(cond_taken), .cycle_phase(cycle_phase), .cycle_start(cycle_start),
    .issue(issue), .flush_cycle(flush_cycle), .dec(dec));

`default_nettype wire

/* File: testbench/ifd_prog_mem.sv */
// program memory model fed from a queue
// assumes the bench fills q; offers change on the falling edge
`default_nettype none

module ifd_prog_mem (
    input wire logic core_clk,
    input wire logic pm_ready,
    input wire logic stall_en,
    output logic [15:0] pm_word,
    output logic pm_valid
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] q[$];
    logic took = 1'b0;

    initial begin
        pm_word = 16'h0000;
        pm_valid = 1'b0;
    end

    // one word per fetch, in order
    always @(posedge core_clk) begin
        took <= pm_ready && pm_valid;
        if (pm_ready && pm_valid) void'(q.pop_front());
    end

    // offers hold until taken; idle data toggles so stale words never match
    always @(negedge core_clk) begin
        if (!pm_valid || took) begin
            if (q.size() > 0 && !(stall_en && $urandom_range(1) == 1)) begin
                pm_valid = 1'b1;
                pm_word = q[0];
            end else begin
                pm_valid = 1'b0;
                pm_word = ~pm_word;
            end
        end
    end
endmodule : ifd_prog_mem

`default_nettype wire

/* File: testbench/ifd_decoder_tb.sv */
// self-checking bench for the decoder and a program memory model
// assumes a 50 ns core clock; expectations queue in issue order
`default_nettype none

module ifd_decoder_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ifd_pkg::*;

    typedef struct packed {
        logic fl;
        ifd_dec_t m;
        ifd_dec_t v;
    } ifd_note_t;

    // --------------------------------
    // signals and instances
    // --------------------------------
    logic core_clk = 1'b0;
    logic sys_rst, ext_set_en, cond_taken, stall_en;
    logic pm_valid, pm_ready, cycle_start, issue, flush_cycle;
    logic [15:0] pm_word;
    logic [1:0] cycle_phase;
    ifd_dec_t dec, m, v;
    ifd_note_t exp_q[$];
    ifd_note_t cur;
    int mismatches = 0;
    int tests_run = 0;

    always #25 core_clk = ~core_clk;

    ifd_prog_mem pm (.core_clk(core_clk), .pm_ready(pm_ready), .stall_en(stall_en),
        .pm_word(pm_word), .pm_valid(pm_valid));
    ifd_decoder dut (.core_clk(core_clk), .sys_rst(sys_rst), .pm_word(pm_word),
        .pm_valid(pm_valid), .pm_ready(pm_ready), .ext_set_en(ext_set_en),
        .cond_taken(cond_taken), .cycle_phase(cycle_phase), .cycle_start(cycle_start),
        .issue(issue), .flush_cycle(flush_cycle), .dec(dec));

    // --------------------------------
    // tasks
    // --------------------------------
    task automatic summarize();
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : summarize

    task automatic chk(input string n, input logic [127:0] e, input logic [127:0] g);
        tests_run++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // queue the masked expectation in m and v
    task automatic note(input logic fl);
        exp_q.push_back('{fl, m, v});
        m = '0;
        v = '0;
    endtask : note

    task automatic lit(input logic [7:0] k);
        m.cat = IFD_CAT_CTRL;
        v.cat = IFD_CAT_LIT;
        m.literal = 12'h0FF;
        v.literal = {4'h0, k};
        note(1'b0);
        pm.q.push_back({8'h0E, k});
    endtask : lit

    // bounded wait until every queued word is checked
    task automatic drain();
        int n;
        n = 0;
        while ((pm.q.size() > 0 || exp_q.size() > 0) && n < 400) begin
            @(negedge core_clk);
            n++;
        end
        if (n >= 400) chk("drain", 128'h0, 128'(pm.q.size() + exp_q.size()));
        repeat (8) @(negedge core_clk);
    endtask : drain

    // --------------------------------
    // result monitor and watchdog
    // --------------------------------
    always @(negedge core_clk) begin
        if (issue === 1'b1) begin
            if (exp_q.size() == 0) chk("issue", 128'h0, 128'h1);
            else begin
                cur = exp_q.pop_front();
                chk("flush", 128'(cur.fl), 128'(flush_cycle));
                chk("dec", 128'(cur.v), 128'(dec & cur.m));
            end
        end
    end

    initial begin
        repeat (20000) @(posedge core_clk);
        mismatches++;
        summarize();
    end

    // --------------------------------
    // main sequence
    // --------------------------------
    initial begin
        logic [7:0] f;
        logic a;
        logic [7:0] ops[3];
        int i;
        ops = '{8'hEC, 8'hED, 8'hEF};
        m = '0;
        v = '0;
        {sys_rst, ext_set_en, cond_taken, stall_en} = 4'b1000;
        void'($urandom(37));
        repeat (6) @(negedge core_clk);
        sys_rst = 1'b0;
        chk("dec_rst", 128'h0, 128'(dec));
        chk("issue_rst", 128'h0, 128'(issue));
        // byte and bit ops with random fields and stalls
        stall_en = 1'b1;
        for (i = 0; i < 8; i++) begin
            f = 8'($urandom);
            a = 1'($urandom);
            m.cat = IFD_CAT_CTRL;
            v.cat = i[0] ? IFD_CAT_BIT : IFD_CAT_BYTE;
            m.file_addr = 12'h0FF;
            v.file_addr = {4'h0, f};
            m.bank_select = 1'b1;
            v.bank_select = a;
            m.cycles = 2'h3;
            v.cycles = IFD_CYC_ONE;
            m.bit_num = i[0] ? 3'h7 : 3'h0;
            v.bit_num = i[0] ? f[2:0] : 3'h0;
            m.dest_to_freg = !i[0];
            v.dest_to_freg = !i[0] && i[1];
            note(1'b0);
            pm.q.push_back(i[0] ? {4'h8, f[2:0], a, f} : {6'h09, i[1], a, f});
        end
        drain();
        stall_en = 1'b0;
        // every table mode
        for (i = 0; i < 4; i++) begin
            m.tbl_mode = IFD_TBL_PRE_INC;
            v.tbl_mode = ifd_tbl_t'(i);
            m.tbl_access = 1'b1;
            v.tbl_access = 1'b1;
            note(1'b0);
            pm.q.push_back(16'h0008 | 16'(i));
        end
        // call, fast call, then jump
        for (i = 0; i < 3; i++) begin
            f = 8'($urandom);
            m.double_word = 1'b1;
            v.double_word = 1'b1;
            m.cycles = 2'h3;
            v.cycles = IFD_CYC_TWO;
            m.prog_addr = 20'hFFFFF;
            v.prog_addr = {f, 4'h5, f};
            m.fast_mode = i < 2;
            v.fast_mode = i == 1;
            m.word_hi = 16'hFFFF;
            v.word_hi = {ops[i], f};
            note(1'b0);
            pm.q.push_back({ops[i], f});
            pm.q.push_back({IFD_SECOND_TAG, f, 4'h5});
        end
        lit(8'h5A);
        // lone second word; a branch drops the next word
        m.orphan_nop = 1'b1;
        v.orphan_nop = 1'b1;
        note(1'b0);
        pm.q.push_back(16'hF5A5);
        m.pc_change = 1'b1;
        v.pc_change = 1'b1;
        note(1'b0);
        pm.q.push_back(16'hD005);
        note(1'b1);
        pm.q.push_back(16'h0E77);
        lit(8'h33);
        drain();
        // compare skip taken, not taken, then a skipped pair that leaves its second word as an orphan
        for (i = 0; i < 3; i++) begin
            cond_taken = i != 1;
            m.conditional = 1'b1;
            v.conditional = 1'b1;
            note(1'b0);
            pm.q.push_back(16'h6012);
            if (i == 1) lit(8'h11);
            else note(1'b1);
            if (i != 1) pm.q.push_back(i == 0 ? 16'h0E11 : 16'hEF12);
            if (i == 2) begin
                m.orphan_nop = 1'b1;
                v.orphan_nop = 1'b1;
                note(1'b0);
                pm.q.push_back(16'hF345);
            end
            drain();
        end
        // extended set off, then on
        for (i = 0; i < 2; i++) begin
            ext_set_en = i[0];
            m.ext_set = 1'b1;
            v.ext_set = i[0];
            note(1'b0);
            pm.q.push_back(16'hE805);
            drain();
        end
        // mid-run reset clears the decode
        sys_rst = 1'b1;
        repeat (2) @(negedge core_clk);
        sys_rst = 1'b0;
        chk("dec_rst2", 128'h0, 128'(dec));
        lit(8'hA5);
        drain();
        summarize();
    end
endmodule : ifd_decoder_tb

`default_nettype wire
